// File: rtl/gpod_decode.sv
/*
  Pel operation decoder: register window, command word decode, start pulse and mix datapath.
  Assumes a same-clock master on a plain strobe port; read data appear one cycle after the read strobe.
*/
// Chosen here: strobed register access.
// Function
// - 32-bit command register at 7Ch
// - command word field positions as documented
// - background pels: colour 00, map 10
// - foreground pels: colour 00, map 10
// - step field selects operation type
// - source map field picks A, B, C
// - destination map field picks A, B, C
// - pattern: maps, fixed foreground, from source
// - mask mode: off, boundary, full
// - drawing mode ignored for block transfers
// - octant sets block traversal order
// - source X and Y offset registers
// - destination X, Y at 78h, 7Ah
// - pattern X and Y offset registers
// - mask origin X and Y registers
// - mix codes including arithmetic 10 to 15
// - width register holds width minus one
`timescale 1ns/1ps
`include "gpod_map.svh"
module gpod_decode
  import gpod_pkg::*;
#(
  parameter int PEL_W = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  // Engine handshake
  input  wire logic             eng_done,
  output logic                  op_start,
  output logic                  op_busy,
  output gpod_dec_t             op_dec,
  output gpod_pos_t             op_pos,
  // Mix datapath
  input  wire logic [PEL_W-1:0] src_pel,
  input  wire logic [PEL_W-1:0] dst_pel,
  input  wire logic             pel_is_fg,
  output logic [PEL_W-1:0]      mix_pel
);

  if (PEL_W < 1 || PEL_W > 8) $error("gpod_decode: PEL_W must be 1 to 8");

  // ***************************************************************
  // Registers
  // ***************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_RUN} gpod_state_t;

  logic [31:0]      cmd_r,    cmd_nxt;
  gpod_pos_t        pos_r,    pos_nxt;
  logic [4:0]       fg_mix_r, fg_mix_nxt;
  logic [4:0]       bg_mix_r, bg_mix_nxt;
  logic [7:0]       fg_col_r, fg_col_nxt;
  logic [7:0]       bg_col_r, bg_col_nxt;
  logic [31:0]      rdata_r,  rdata_nxt;
  logic             start_r,  start_nxt;
  gpod_dec_t        dec_r,    dec_nxt;
  logic [PEL_W-1:0] mix_r,    mix_nxt;
  gpod_state_t      state_r,  state_nxt;
  logic             busy_r,   busy_nxt;
  logic             eng_done_q;

  // ***************************************************************
  // Field decode
  // ***************************************************************
  logic [3:0] step_f;
  logic [1:0] bg_f;
  logic [1:0] fg_f;
  logic [1:0] mask_f;
  logic [2:0] oct_f;
  logic [2:0] smap_sel;
  logic [2:0] dmap_sel;
  logic [2:0] pmap_sel;
  logic       pat_fg;
  logic       pat_src;
  logic       smap_ok;
  logic       dmap_ok;
  logic       pmap_ok;
  logic       blt_op;
  logic       step_ok;
  logic       src_ok;
  logic       mask_ok;
  logic [PEL_W-1:0] src_eff;
  logic [PEL_W-1:0] mix_res;

  always_comb begin
    bg_f   = cmd_r[`GPOD_BG_SRC_HI:`GPOD_BG_SRC_LO];
    fg_f   = cmd_r[`GPOD_FG_SRC_HI:`GPOD_FG_SRC_LO];
    step_f = cmd_r[`GPOD_STEP_HI:`GPOD_STEP_LO];
    mask_f = cmd_r[`GPOD_MASK_HI:`GPOD_MASK_LO];
    oct_f  = cmd_r[`GPOD_OCT_HI:`GPOD_OCT_LO];
  end

  gpod_map_decode u_smap (
    .code      (cmd_r[`GPOD_SMAP_HI:`GPOD_SMAP_LO]),
    .allow_pat (1'b0),
    .sel       (smap_sel),
    .fixed_fg  (),
    .from_src  (),
    .valid     (smap_ok)
  );

  gpod_map_decode u_dmap (
    .code      (cmd_r[`GPOD_DMAP_HI:`GPOD_DMAP_LO]),
    .allow_pat (1'b0),
    .sel       (dmap_sel),
    .fixed_fg  (),
    .from_src  (),
    .valid     (dmap_ok)
  );

  gpod_map_decode u_pmap (
    .code      (cmd_r[`GPOD_PMAP_HI:`GPOD_PMAP_LO]),
    .allow_pat (1'b1),
    .sel       (pmap_sel),
    .fixed_fg  (pat_fg),
    .from_src  (pat_src),
    .valid     (pmap_ok)
  );

  always_comb begin
    dec_nxt = '0;
    blt_op  = step_f[3];
    step_ok = 1'b0;
    case (step_f)
      GPOD_STEP_DSR, GPOD_STEP_LDR, GPOD_STEP_DSW, GPOD_STEP_LDW,
      GPOD_STEP_BLT, GPOD_STEP_IBLT, GPOD_STEP_FBLT: step_ok = 1'b1;
      default: step_ok = 1'b0;
    endcase
    src_ok  = (bg_f == GPOD_SRC_COLOR || bg_f == GPOD_SRC_MAP) &&
              (fg_f == GPOD_SRC_COLOR || fg_f == GPOD_SRC_MAP);
    mask_ok = (mask_f != 2'h3);
    dec_nxt.bg_from_map  = (bg_f == GPOD_SRC_MAP);
    dec_nxt.fg_from_map  = (fg_f == GPOD_SRC_MAP);
    dec_nxt.is_blt       = step_ok && blt_op;
    dec_nxt.is_line      = step_ok && !blt_op && step_f[0];
    dec_nxt.is_read      = step_ok && !blt_op && !step_f[2];
    dec_nxt.invert       = (step_f == GPOD_STEP_IBLT);
    dec_nxt.area_fill    = (step_f == GPOD_STEP_FBLT);
    dec_nxt.src_map_sel  = smap_sel;
    dec_nxt.dst_map_sel  = dmap_sel;
    dec_nxt.pat_map_sel  = pmap_sel;
    dec_nxt.pat_fixed_fg = pat_fg;
    dec_nxt.pat_from_src = pat_src;
    dec_nxt.mask_bound   = (mask_f == GPOD_MASK_BOUND);
    dec_nxt.mask_full    = (mask_f == GPOD_MASK_FULL);
    // Block transfers walk rectangles, so the line style bits are forced off.
    dec_nxt.draw_mode    = blt_op ? 2'h0 : cmd_r[`GPOD_DMODE_HI:`GPOD_DMODE_LO];
    dec_nxt.x_left       = oct_f[2];
    dec_nxt.y_up         = oct_f[1];
    // A reserved source code is refused even when no source map is read.
    dec_nxt.illegal      = !(step_ok && src_ok && mask_ok && smap_ok && dmap_ok && pmap_ok);
  end

  // ***************************************************************
  // Register writes, start and read-back
  // ***************************************************************
  always_comb begin
    cmd_nxt    = cmd_r;
    pos_nxt    = pos_r;
    fg_mix_nxt = fg_mix_r;
    bg_mix_nxt = bg_mix_r;
    fg_col_nxt = fg_col_r;
    bg_col_nxt = bg_col_r;
    start_nxt  = 1'b0;
    state_nxt  = state_r;
    rdata_nxt  = 32'h0000_0000;
    if (reg_wr) begin
      case (reg_addr)
        `GPOD_OFF_OP_CMD: begin
          cmd_nxt = reg_wdata;
          // A command written while busy is stored but does not restart the engine.
          start_nxt = (state_r == ST_IDLE);
        end
        `GPOD_OFF_DEST_X:    pos_nxt.dst_x     = reg_wdata[15:0];
        `GPOD_OFF_DEST_Y:    pos_nxt.dst_y     = reg_wdata[15:0];
        `GPOD_OFF_SRC_X:     pos_nxt.src_x     = reg_wdata[15:0];
        `GPOD_OFF_SRC_Y:     pos_nxt.src_y     = reg_wdata[15:0];
        `GPOD_OFF_PAT_X:     pos_nxt.pat_x     = reg_wdata[15:0];
        `GPOD_OFF_PAT_Y:     pos_nxt.pat_y     = reg_wdata[15:0];
        `GPOD_OFF_MASK_X:    pos_nxt.mask_x    = reg_wdata[15:0];
        `GPOD_OFF_MASK_Y:    pos_nxt.mask_y    = reg_wdata[15:0];
        `GPOD_OFF_OP_WIDTH:  pos_nxt.width_m1  = reg_wdata[15:0];
        `GPOD_OFF_OP_HEIGHT: pos_nxt.height_m1 = reg_wdata[15:0];
        `GPOD_OFF_FG_MIX:    fg_mix_nxt        = reg_wdata[4:0];
        `GPOD_OFF_BG_MIX:    bg_mix_nxt        = reg_wdata[4:0];
        `GPOD_OFF_FG_COLOR:  fg_col_nxt        = reg_wdata[7:0];
        `GPOD_OFF_BG_COLOR:  bg_col_nxt        = reg_wdata[7:0];
        default: ;
      endcase
    end
    case (state_r)
      ST_IDLE: if (start_nxt) state_nxt = ST_RUN;
      ST_RUN:  if (eng_done_q) state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    // Busy has its own flop so that the output carries no decode logic.
    busy_nxt = (state_nxt == ST_RUN);
    if (reg_rd) begin
      case (reg_addr)
        `GPOD_OFF_OP_CMD:    rdata_nxt = cmd_r;
        `GPOD_OFF_DEST_X:    rdata_nxt = {16'h0000, pos_r.dst_x};
        `GPOD_OFF_DEST_Y:    rdata_nxt = {16'h0000, pos_r.dst_y};
        `GPOD_OFF_SRC_X:     rdata_nxt = {16'h0000, pos_r.src_x};
        `GPOD_OFF_SRC_Y:     rdata_nxt = {16'h0000, pos_r.src_y};
        `GPOD_OFF_PAT_X:     rdata_nxt = {16'h0000, pos_r.pat_x};
        `GPOD_OFF_PAT_Y:     rdata_nxt = {16'h0000, pos_r.pat_y};
        `GPOD_OFF_MASK_X:    rdata_nxt = {16'h0000, pos_r.mask_x};
        `GPOD_OFF_MASK_Y:    rdata_nxt = {16'h0000, pos_r.mask_y};
        `GPOD_OFF_OP_WIDTH:  rdata_nxt = {16'h0000, pos_r.width_m1};
        `GPOD_OFF_OP_HEIGHT: rdata_nxt = {16'h0000, pos_r.height_m1};
        `GPOD_OFF_FG_MIX:    rdata_nxt = {27'h0, fg_mix_r};
        `GPOD_OFF_BG_MIX:    rdata_nxt = {27'h0, bg_mix_r};
        `GPOD_OFF_FG_COLOR:  rdata_nxt = {24'h000000, fg_col_r};
        `GPOD_OFF_BG_COLOR:  rdata_nxt = {24'h000000, bg_col_r};
        `GPOD_OFF_STATUS:    rdata_nxt = {30'h0, dec_r.illegal, busy_r};
        default:             rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ***************************************************************
  // Mix datapath
  // ***************************************************************
  always_comb begin
    // Colour registers stand in for the source when the field selects colour.
    if (pel_is_fg) begin
      src_eff = dec_r.fg_from_map ? src_pel : fg_col_r[PEL_W-1:0];
    end else begin
      src_eff = dec_r.bg_from_map ? src_pel : bg_col_r[PEL_W-1:0];
    end
    mix_nxt = mix_res;
  end

  gpod_mix_unit #(
    .W (PEL_W)
  ) u_mix (
    .code (pel_is_fg ? fg_mix_r : bg_mix_r),
    .src  (src_eff),
    .dst  (dst_pel),
    .res  (mix_res)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_r      <= `GPOD_RST_CMD;
      pos_r      <= '0;
      fg_mix_r   <= 5'h00;
      bg_mix_r   <= 5'h00;
      fg_col_r   <= 8'h00;
      bg_col_r   <= 8'h00;
      rdata_r    <= 32'h0000_0000;
      start_r    <= 1'b0;
      dec_r      <= '0;
      mix_r      <= '0;
      state_r    <= ST_IDLE;
      busy_r     <= 1'b0;
      eng_done_q <= 1'b0;
    end else begin
      cmd_r      <= cmd_nxt;
      pos_r      <= pos_nxt;
      fg_mix_r   <= fg_mix_nxt;
      bg_mix_r   <= bg_mix_nxt;
      fg_col_r   <= fg_col_nxt;
      bg_col_r   <= bg_col_nxt;
      rdata_r    <= rdata_nxt;
      start_r    <= start_nxt;
      dec_r      <= dec_nxt;
      mix_r      <= mix_nxt;
      state_r    <= state_nxt;
      busy_r     <= busy_nxt;
      eng_done_q <= eng_done;
    end
  end

  always_comb begin
    reg_rdata = rdata_r;
    op_start  = start_r;
    op_busy   = busy_r;
    op_dec    = dec_r;
    op_pos    = pos_r;
    mix_pel   = mix_r;
  end

endmodule

// File: shared/gpod_map.svh
/*
  Register offsets, field positions, reset values and timing counts for the pel operation decoder.
  Assumes a byte-addressed register window; included by bare name wherever the map is needed.
*/
`ifndef GPOD_MAP_SVH
`define GPOD_MAP_SVH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define GPOD_OFF_FG_MIX      8'h48
`define GPOD_OFF_BG_MIX      8'h49
`define GPOD_OFF_BG_COLOR    8'h5c
`define GPOD_OFF_FG_COLOR    8'h58
`define GPOD_OFF_OP_WIDTH    8'h60
`define GPOD_OFF_OP_HEIGHT   8'h62
`define GPOD_OFF_SRC_X       8'h70
`define GPOD_OFF_SRC_Y       8'h72
`define GPOD_OFF_PAT_X       8'h74
`define GPOD_OFF_PAT_Y       8'h76
`define GPOD_OFF_DEST_X      8'h78
`define GPOD_OFF_DEST_Y      8'h7a
`define GPOD_OFF_OP_CMD      8'h7c
`define GPOD_OFF_MASK_X      8'h6c
`define GPOD_OFF_MASK_Y      8'h6e
`define GPOD_OFF_STATUS      8'h80

// ***************************************************************
// Command word field positions
// ***************************************************************
`define GPOD_BG_SRC_HI   31
`define GPOD_BG_SRC_LO   30
`define GPOD_FG_SRC_HI   29
`define GPOD_FG_SRC_LO   28
`define GPOD_STEP_HI     27
`define GPOD_STEP_LO     24
`define GPOD_SMAP_HI     23
`define GPOD_SMAP_LO     20
`define GPOD_DMAP_HI     19
`define GPOD_DMAP_LO     16
`define GPOD_PMAP_HI     15
`define GPOD_PMAP_LO     12
`define GPOD_MASK_HI     7
`define GPOD_MASK_LO     6
`define GPOD_DMODE_HI    5
`define GPOD_DMODE_LO    4
`define GPOD_OCT_HI      2
`define GPOD_OCT_LO      0

// ***************************************************************
// Reset values and timing counts
// ***************************************************************
`define GPOD_RST_CMD     32'h0000_0000
`define GPOD_RST_POS     16'h0000
`define GPOD_STEP_NS     8
`define GPOD_CLK_NS      8
`define GPOD_STEP_CYC    ((`GPOD_STEP_NS + `GPOD_CLK_NS - 1) / `GPOD_CLK_NS)

`endif

// File: shared/gpod_pkg.sv
/*
  Types for the pel operation decoder: field encodings and the decoded command carrier.
  Assumes gpod_map.svh is compiled alongside; this package holds types only.
*/
package gpod_pkg;

  typedef enum logic [1:0] {
    GPOD_SRC_COLOR = 2'h0,
    GPOD_SRC_MAP   = 2'h2
  } gpod_src_t;

  typedef enum logic [3:0] {
    GPOD_STEP_DSR   = 4'h2,
    GPOD_STEP_LDR   = 4'h3,
    GPOD_STEP_DSW   = 4'h4,
    GPOD_STEP_LDW   = 4'h5,
    GPOD_STEP_BLT   = 4'h8,
    GPOD_STEP_IBLT  = 4'h9,
    GPOD_STEP_FBLT  = 4'ha
  } gpod_step_t;

  typedef enum logic [3:0] {
    GPOD_MAP_A      = 4'h1,
    GPOD_MAP_B      = 4'h2,
    GPOD_MAP_C      = 4'h3,
    GPOD_MAP_FG     = 4'h8,
    GPOD_MAP_FROMSRC = 4'h9
  } gpod_map_t;

  typedef enum logic [1:0] {
    GPOD_MASK_OFF   = 2'h0,
    GPOD_MASK_BOUND = 2'h1,
    GPOD_MASK_FULL  = 2'h2
  } gpod_mask_t;

  // Decoded command fields handed to the drawing engine.
  typedef struct packed {
    logic       bg_from_map;
    logic       fg_from_map;
    logic       is_blt;
    logic       is_line;
    logic       is_read;
    logic       invert;
    logic       area_fill;
    logic [2:0] src_map_sel;
    logic [2:0] dst_map_sel;
    logic [2:0] pat_map_sel;
    logic       pat_fixed_fg;
    logic       pat_from_src;
    logic       mask_bound;
    logic       mask_full;
    logic [1:0] draw_mode;
    logic       x_left;
    logic       y_up;
    logic       illegal;
  } gpod_dec_t;

  // Start positions and operation size handed to the drawing engine.
  typedef struct packed {
    logic [15:0] src_x;
    logic [15:0] src_y;
    logic [15:0] dst_x;
    logic [15:0] dst_y;
    logic [15:0] pat_x;
    logic [15:0] pat_y;
    logic [15:0] mask_x;
    logic [15:0] mask_y;
    logic [15:0] width_m1;
    logic [15:0] height_m1;
  } gpod_pos_t;

endpackage

// File: rtl/gpod_map_decode.sv
/*
  Decodes a 4-bit map selection field into a one-hot map select and a validity flag.
  Assumes a combinational context; the caller registers the result.
*/
`timescale 1ns/1ps
module gpod_map_decode
  import gpod_pkg::*;
(
  // Field in
  input  wire logic [3:0] code,
  // Pattern extensions allowed
  input  wire logic       allow_pat,
  // Decoded out
  output logic [2:0]      sel,
  output logic            fixed_fg,
  output logic            from_src,
  output logic            valid
);

  always_comb begin
    sel      = 3'h0;
    fixed_fg = 1'b0;
    from_src = 1'b0;
    valid    = 1'b1;
    case (code)
      GPOD_MAP_A: sel = 3'h1;
      GPOD_MAP_B: sel = 3'h2;
      GPOD_MAP_C: sel = 3'h4;
      GPOD_MAP_FG: begin
        fixed_fg = allow_pat;
        valid    = allow_pat;
      end
      GPOD_MAP_FROMSRC: begin
        from_src = allow_pat;
        valid    = allow_pat;
      end
      default: valid = 1'b0;
    endcase
  end

endmodule

// File: rtl/gpod_mix_unit.sv
/*
  Mix function of source and destination pels, selected by a 5-bit code.
  Assumes pels are unsigned; the caller registers the result.
*/
`timescale 1ns/1ps
module gpod_mix_unit #(
  parameter int W = 8
) (
  // Operands
  input  wire logic [4:0]   code,
  input  wire logic [W-1:0] src,
  input  wire logic [W-1:0] dst,
  // Result
  output logic [W-1:0]      res
);

  logic [W:0] sum;
  logic [W:0] dms;
  logic [W:0] smd;

  if (W < 1 || W > 16) $error("gpod_mix_unit: W out of range");

  always_comb begin
    sum = {1'b0, src} + {1'b0, dst};
    dms = {1'b0, dst} - {1'b0, src};
    smd = {1'b0, src} - {1'b0, dst};
    case (code)
      5'h00: res = '0;
      5'h01: res = src & dst;
      5'h02: res = src & ~dst;
      5'h03: res = src;
      5'h04: res = ~src & dst;
      5'h05: res = dst;
      5'h06: res = src ^ dst;
      5'h07: res = src | dst;
      5'h08: res = ~src & ~dst;
      5'h09: res = src ^ ~dst;
      5'h0a: res = ~dst;
      5'h0b: res = src | ~dst;
      5'h0c: res = ~src;
      5'h0d: res = ~src | dst;
      5'h0e: res = ~src | ~dst;
      5'h0f: res = '1;
      5'h10: res = (src > dst) ? src : dst;
      5'h11: res = (src < dst) ? src : dst;
      5'h12: res = sum[W] ? '1 : sum[W-1:0];
      5'h13: res = dms[W] ? '0 : dms[W-1:0];
      5'h14: res = smd[W] ? '0 : smd[W-1:0];
      5'h15: res = sum[W:1];
      default: res = '0;
    endcase
  end

endmodule

// File: verif/gpod_monitor.sv
/*
  Port checker for the pel operation decoder: start pulse, busy span, read port and command decode.
  Assumes a single clock domain and is bound onto every gpod_decode instance.
*/
`timescale 1ns/1ps
`include "gpod_map.svh"
module gpod_monitor
  import gpod_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Engine handshake
  input wire logic        eng_done,
  input wire logic        op_start,
  input wire logic        op_busy,
  input wire gpod_dec_t   op_dec
);
  // ***************************************************************
  // Shadow of the command register
  // ***************************************************************
  // The shadow lets decode checks compare against the written word, not the design's copy.
  logic [31:0] cmd_r;
  logic [31:0] cmd_nxt;
  logic        cmd_wr;
  assign cmd_wr = reg_wr && (reg_addr == `GPOD_OFF_OP_CMD);
  always_comb begin
    cmd_nxt = cmd_r;
    if (sys_rst) begin
      cmd_nxt = 32'h0;
    end else if (cmd_wr) begin
      cmd_nxt = reg_wdata;
    end
  end
  always_ff @(posedge sys_clk) begin
    cmd_r <= cmd_nxt;
  end
  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_cmd_starts_op: assert property (cmd_wr && !op_busy |=> op_start && op_busy)
    else $error("command write while idle gave no start");
  a_start_one_cycle: assert property (op_start |=> !op_start)
    else $error("start pulse longer than one cycle");
  a_start_has_cause: assert property (op_start |-> $past(cmd_wr && !op_busy))
    else $error("start without an idle command write");
  a_done_ends_busy: assert property (op_busy && eng_done |=> ##1 !op_busy)
    else $error("busy did not end two cycles after done");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_cmd_read_back: assert property (reg_rd && reg_addr == `GPOD_OFF_OP_CMD |=> reg_rdata == $past(cmd_r))
    else $error("command read back differs from written word");
  // The decode lands one cycle after the start pulse, from the word stored at the start.
  a_blt_octant: assert property ($past(op_start) && op_dec.is_blt |-> op_dec.x_left == $past(cmd_r[2])
    && op_dec.y_up == $past(cmd_r[1]))
    else $error("block transfer direction wrong");
  a_blt_mode_zero: assert property ($past(op_start) && $past(cmd_r[27]) |-> op_dec.draw_mode == 2'h0)
    else $error("drawing mode not ignored for block transfer");
  a_src_select: assert property ($past(op_start) |-> op_dec.bg_from_map == ($past(cmd_r[31:30]) == 2'h2)
    && op_dec.fg_from_map == ($past(cmd_r[29:28]) == 2'h2))
    else $error("pel source selection wrong");
  a_step_kind: assert property ($past(op_start) |->
    op_dec.is_blt == ($past(cmd_r[27:24]) inside {4'h8, 4'h9, 4'ha}))
    else $error("step function kind wrong");
  c_blt_start: cover property ($past(op_start) && op_dec.is_blt);
  c_line_start: cover property ($past(op_start) && op_dec.is_line);
  c_done_seen: cover property (op_busy && eng_done);
endmodule

bind gpod_decode gpod_monitor mon_u (
  .sys_clk   (sys_clk),
  .sys_rst   (sys_rst),
  .reg_addr  (reg_addr),
  .reg_wdata (reg_wdata),
  .reg_wr    (reg_wr),
  .reg_rd    (reg_rd),
  .reg_rdata (reg_rdata),
  .eng_done  (eng_done),
  .op_start  (op_start),
  .op_busy   (op_busy),
  .op_dec    (op_dec)
);

// File: verif/tb_top.sv
/*
  Self-checking bench for the pel operation decoder, driving the register port and engine handshake.
  Assumes the design and its bound checker are compiled before it.
*/
`timescale 1ns/1ps
`include "gpod_map.svh"
module tb_top
  import gpod_pkg::*;
;
  logic        sys_clk   = 1'b0;
  logic        sys_rst   = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        eng_done  = 1'b0;
  logic [7:0]  src_pel   = 8'hc0;
  logic [7:0]  dst_pel   = 8'h50;
  logic        pel_is_fg = 1'b1;
  logic [31:0] reg_rdata;
  logic        op_start;
  logic        op_busy;
  gpod_dec_t   op_dec;
  gpod_pos_t   op_pos;
  logic [7:0]  mix_pel;
  logic [159:0] exp_pos;
  int          err_count = 0;
  int          n_tests   = 0;
  logic [7:0]  pos_addr [10] = '{8'h70, 8'h72, 8'h78, 8'h7a, 8'h74, 8'h76, 8'h6c, 8'h6e, 8'h60, 8'h62};
  logic [31:0] cmd_tbl [9] = '{32'h08118000, 32'ha9239077, 32'h0a321094, 32'h02112022, 32'h03113016,
                               32'h04118030, 32'h05118001, 32'h08118f08, 32'h08108000};
  logic [4:0]  mix_code [11] = '{5'h00, 5'h03, 5'h05, 5'h06, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15};
  logic [7:0]  mix_exp [11] = '{8'h00, 8'hc0, 8'h50, 8'h90, 8'hff, 8'hc0, 8'h50, 8'hff, 8'h00, 8'h70, 8'h88};

  always #4 sys_clk = ~sys_clk;

  gpod_decode #(.PEL_W(8)) dut_u (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_rdata (reg_rdata),
    .eng_done  (eng_done),
    .op_start  (op_start),
    .op_busy   (op_busy),
    .op_dec    (op_dec),
    .op_pos    (op_pos),
    .src_pel   (src_pel),
    .dst_pel   (dst_pel),
    .pel_is_fg (pel_is_fg),
    .mix_pel   (mix_pel)
  );

  // ***************************************************************
  // Access tasks
  // ***************************************************************
  task automatic check(input string what, input logic [159:0] seen, input logic [159:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // The trailing edge keeps two back-to-back writes from assigning the strobe twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
    @(posedge sys_clk);
  endtask

  function automatic logic [2:0] one_hot(input logic [3:0] c);
    return (c >= 4'h1 && c <= 4'h3) ? 3'b001 << (c - 4'h1) : 3'b000;
  endfunction

  function automatic gpod_dec_t exp_dec(input logic [31:0] c);
    gpod_dec_t  e;
    logic [3:0] st;
    st = c[27:24];
    e = '0;
    e.bg_from_map  = c[31:30] == 2'h2;
    e.fg_from_map  = c[29:28] == 2'h2;
    e.is_blt       = st inside {4'h8, 4'h9, 4'ha};
    e.is_line      = st inside {4'h3, 4'h5};
    e.is_read      = st inside {4'h2, 4'h3};
    e.invert       = st == 4'h9;
    e.area_fill    = st == 4'ha;
    e.src_map_sel  = one_hot(c[23:20]);
    e.dst_map_sel  = one_hot(c[19:16]);
    e.pat_map_sel  = one_hot(c[15:12]);
    e.pat_fixed_fg = c[15:12] == 4'h8;
    e.pat_from_src = c[15:12] == 4'h9;
    e.mask_bound   = c[7:6] == 2'h1;
    e.mask_full    = c[7:6] == 2'h2;
    e.draw_mode    = st[3] ? 2'h0 : c[5:4];
    e.x_left       = c[2];
    e.y_up         = c[1];
    e.illegal      = !(c[31:28] inside {4'h0, 4'h2, 4'h8, 4'ha}) || !(st inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8,
                     4'h9, 4'ha}) || one_hot(c[23:20]) == 3'h0 || one_hot(c[19:16]) == 3'h0
                     || !(c[15:12] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9}) || c[7:6] == 2'h3;
    return e;
  endfunction

  task automatic run_cmd(input logic [31:0] c);
    reg_addr  <= `GPOD_OFF_OP_CMD;
    reg_wdata <= c;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
    check("op_start", op_start, 1'b1);
    @(posedge sys_clk);
    eng_done <= 1'b1;
    #1;
    check("op_start", op_start, 1'b0);
    check("op_dec", op_dec, exp_dec(c));
    @(posedge sys_clk);
    eng_done <= 1'b0;
    #1;
    check("op_busy", op_busy, 1'b1);
    @(posedge sys_clk);
    #1;
    check("op_busy", op_busy, 1'b0);
    @(posedge sys_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd_chk(`GPOD_OFF_OP_CMD, 32'h0);
    rd_chk(`GPOD_OFF_DEST_X, 32'h0);
    rd_chk(8'h04, 32'h0);
    check("op_busy", op_busy, 1'b0);
    $display("test reset values done");
    exp_pos = '0;
    foreach (pos_addr[i]) begin
      wr(pos_addr[i], {16'hffff, pos_addr[i], pos_addr[i]});
      exp_pos = {exp_pos[143:0], pos_addr[i], pos_addr[i]};
    end
    check("op_pos", op_pos, exp_pos);
    rd_chk(`GPOD_OFF_DEST_X, 32'h7878);
    rd_chk(`GPOD_OFF_DEST_Y, 32'h7a7a);
    $display("test position registers done");
    foreach (cmd_tbl[i]) begin
      run_cmd(cmd_tbl[i]);
    end
    rd_chk(`GPOD_OFF_OP_CMD, 32'h08108000);
    $display("test command decode done");
    wr(`GPOD_OFF_OP_CMD, 32'h08118000);
    wr(`GPOD_OFF_OP_CMD, 32'h05118001);
    rd_chk(`GPOD_OFF_STATUS, 32'h1);
    rd_chk(`GPOD_OFF_OP_CMD, 32'h05118001);
    eng_done <= 1'b1;
    @(posedge sys_clk);
    eng_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rd_chk(`GPOD_OFF_STATUS, 32'h0);
    $display("test write while busy done");
    wr(`GPOD_OFF_FG_COLOR, 32'hc0);
    wr(`GPOD_OFF_BG_MIX, 32'h5);
    foreach (mix_code[i]) begin
      wr(`GPOD_OFF_FG_MIX, {27'h0, mix_code[i]});
      #1;
      check("mix_pel", mix_pel, mix_exp[i]);
      @(posedge sys_clk);
    end
    pel_is_fg <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("mix_pel", mix_pel, 8'h50);
    $display("test mix functions done");
    give_verdict();
  end

  // Whole run needs about 135 cycles; the margin covers a stalled handshake.
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    give_verdict();
  end
endmodule
